// ---- design/fcsm_cfg.svh ----
// flash command sequencer constants: offsets, fields, operands, timing
// assumes inclusion by the top design file and the three sim files
`ifndef FCSM_CFG_SVH
`define FCSM_CFG_SVH

// register byte offsets (aligned words)
`define FCSM_OFS_CTRL    12'h000
`define FCSM_OFS_SECTEN  12'h004
`define FCSM_OFS_STAT    12'h008
`define FCSM_OFS_CMD     12'h00C
`define FCSM_OFS_DATA    12'h010
`define FCSM_OFS_RDCHK   12'h014
`define FCSM_OFS_SUPPLY  12'h018

// control register fields
`define FCSM_CTRL_PIPE   0
`define FCSM_CTRL_OTP    1
`define FCSM_CTRL_CFG    2
`define FCSM_CTRL_WREN   4
`define FCSM_CTRL_BANK_L 8
`define FCSM_CTRL_RST    32'h0000_0000

// module status fields
`define FCSM_ST_SECTOR_LOCKED_FLAG    0
`define FCSM_ST_COMMAND_STATUS_FLAG    1
`define FCSM_ST_BUSY     2
`define FCSM_ST_SUPPLY   3
`define FCSM_ST_INVALID_PROGRAM_DATA_FLAG   4
`define FCSM_ST_PSUSP    5
`define FCSM_ST_ESUSP    6

// command operands
`define FCSM_OP_PROG     16'h0010
`define FCSM_OP_ERASE    16'h0020
`define FCSM_OP_CLR      16'h0040
`define FCSM_OP_SUSP     16'h0080
`define FCSM_OP_RESP     16'h0200
`define FCSM_OP_RESE     16'h0400
`define FCSM_OP_OTP      16'h0800
`define FCSM_OP_VALID    16'h1000

// timing: suspend latency bound and work durations
`define FCSM_SUSP_NS     2000
`define FCSM_CLK_NS      5
`define FCSM_PROG_CYC    64
`define FCSM_ERASE_CYC   256
`endif

// ---- design/fcsm_pkg.sv ----
// flash command sequencer types
// assumes no surrounding package; constants live in the cfg header
package fcsm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_DATA, ST_CHECK, ST_RUN, ST_SUSPENDING
  } fcsm_state_type;
  typedef enum logic [1:0] {
    OPK_PROG, OPK_ERASE, OPK_VALID
  } fcsm_kind_type;
endpackage

// ---- design/fcsm_top.sv ----
// flash command state machine with AXI4-Lite register slave
// assumes one 200 MHz clock, synchronous low reset, supply pin async
//
// Behaviour
// - idle after reset and after every command
// - decode the eight 16-bit command operands
// - two-write commands versus one-write commands
// - commands only with pipeline off; config forces off
// - wait forever for second write, latch target
// - register access between writes keeps pending command
// - busy set by any command but clear status and suspend
// - only completion, suspend or reset ends operation
// - check sector protection, then work, busy held
// - while busy only suspend is honoured
// - active bank reads invalid during operation
// - suspended program: address invalid; erase: sector
// - busy drops within 2.0 us of suspend
// - supply fault during work sets status bit 3
// - completion returns idle; reissue for next
// - suspend acts only when busy and working
// - suspended program allows erase elsewhere, vice versa
// - one active; no second program or erase suspended
// - resume with nothing suspended does nothing
// - protected sector halts and sets locked bit 0
// - clear status when idle clears four flags
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "fcsm_cfg.svh"

module fcsm_top #(
  parameter int SUSP_CYC = (`FCSM_SUSP_NS / `FCSM_CLK_NS) / 4
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  input  wire logic        i_supply_fault,
  input  wire logic [11:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [11:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic             o_busy
);

  // the suspend bound is 400 cycles; a quarter keeps margin
  initial begin
    if (SUSP_CYC < 1 || SUSP_CYC > 400)
      $error("SUSP_CYC out of range");
  end

  // ----------------------------------------------------------------
  // supply pin synchroniser
  // ----------------------------------------------------------------
  logic [2:0] sup_sync_r;
  logic       sup_flt_r;
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      sup_sync_r <= 3'h0;
      sup_flt_r  <= 1'b0;
    end else begin
      sup_sync_r <= {sup_sync_r[1:0], i_supply_fault};
      if (sup_sync_r[1] == sup_sync_r[2])
        sup_flt_r <= sup_sync_r[2];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel capture
  // ----------------------------------------------------------------
  logic [11:0] awa_r;
  logic        aw_have_r;
  logic [31:0] wd_r;
  logic        w_have_r;
  wire         wr_go = aw_have_r && w_have_r && !o_bvalid;
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      awa_r     <= 12'h000;
      aw_have_r <= 1'b0;
      wd_r      <= 32'h0000_0000;
      w_have_r  <= 1'b0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= 2'h0;
    end else begin
      o_awready <= !aw_have_r && !(i_awvalid && o_awready);
      o_wready  <= !w_have_r && !(i_wvalid && o_wready);
      if (i_awvalid && o_awready) begin
        awa_r     <= i_awaddr;
        aw_have_r <= 1'b1;
      end
      if (i_wvalid && o_wready) begin
        wd_r     <= i_wdata;
        w_have_r <= 1'b1;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= addr_ok(awa_r) ? 2'h0 : 2'h2;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // true for mapped register offsets
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a <= `FCSM_OFS_SUPPLY) && (a[1:0] == 2'h0);
  endfunction

  wire wr_ctrl = wr_go && awa_r == `FCSM_OFS_CTRL;
  wire wr_sec  = wr_go && awa_r == `FCSM_OFS_SECTEN;
  wire wr_cmd  = wr_go && awa_r == `FCSM_OFS_CMD;
  wire wr_dat  = wr_go && awa_r == `FCSM_OFS_DATA;
  wire wr_chk  = wr_go && awa_r == `FCSM_OFS_RDCHK;

  // ----------------------------------------------------------------
  // control, sector enable and read-check registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] secen_r;
  logic [31:0] rdchk_r;
  logic [31:0] ctrl_nxt;
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl)
      ctrl_nxt = wd_r & 32'h0000_0717;
    if (ctrl_nxt[`FCSM_CTRL_CFG])
      ctrl_nxt[`FCSM_CTRL_PIPE] = 1'b0;
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      ctrl_r  <= `FCSM_CTRL_RST;
      secen_r <= 32'h0000_0000;
      rdchk_r <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      if (wr_sec)
        secen_r <= wd_r;
      if (wr_chk)
        rdchk_r <= wd_r;
    end
  end

  wire       wr_en    = ctrl_r[`FCSM_CTRL_WREN];
  wire       pipe_off = !ctrl_r[`FCSM_CTRL_PIPE];
  wire [2:0] sel_bank = ctrl_r[`FCSM_CTRL_BANK_L +: 3];

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire        cmd_ok = wr_cmd && wr_en && pipe_off;
  wire [15:0] opnd   = wd_r[15:0];
  wire is_prog  = opnd == `FCSM_OP_PROG || opnd == `FCSM_OP_OTP;
  wire is_erase = opnd == `FCSM_OP_ERASE;
  wire is_valid = opnd == `FCSM_OP_VALID;
  wire is_clr   = opnd == `FCSM_OP_CLR;
  wire is_susp  = opnd == `FCSM_OP_SUSP;
  wire is_resp  = opnd == `FCSM_OP_RESP;
  wire is_rese  = opnd == `FCSM_OP_RESE;

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  fcsm_pkg::fcsm_state_type st_r;
  fcsm_pkg::fcsm_kind_type  kind_r;
  logic [15:0] cnt_r;
  logic [8:0]  scnt_r;
  logic        psusp_r;
  logic        esusp_r;
  logic [2:0]  tbank_r;
  logic [31:0] taddr_r;
  logic [15:0] tdata_r;
  logic [15:0] pcnt_r;
  logic [2:0]  pbank_r;
  logic [31:0] paddr_r;
  logic [15:0] ecnt_r;
  logic [2:0]  ebank_r;
  logic [31:0] eaddr_r;
  logic        sector_locked_flag_r;
  logic        command_status_flag_r;
  logic        supe_r;
  logic        invd_r;

  // target sector index from address bits 20:16, assumed layout
  wire [4:0] tsec    = taddr_r[20:16];
  wire       sec_ok  = secen_r[tsec];
  wire       working = st_r == fcsm_pkg::ST_RUN ||
                       st_r == fcsm_pkg::ST_SUSPENDING;
  wire       run_pe  = working && kind_r != fcsm_pkg::OPK_VALID;
  wire       busy    = st_r == fcsm_pkg::ST_CHECK || working;
  // a new job of a kind that is already suspended is refused
  wire new_ok = (is_prog && !psusp_r) || (is_erase && !esusp_r) ||
                is_valid;
  wire do_susp = cmd_ok && is_susp && run_pe &&
                 st_r == fcsm_pkg::ST_RUN;
  // each kind resumes on its own; the other may stay suspended
  wire do_resp = cmd_ok && is_resp && psusp_r;
  wire do_rese = cmd_ok && is_rese && esusp_r;

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      st_r    <= fcsm_pkg::ST_IDLE;
      kind_r  <= fcsm_pkg::OPK_PROG;
      cnt_r   <= 16'h0000;
      scnt_r  <= 9'h000;
      psusp_r <= 1'b0;
      esusp_r <= 1'b0;
      tbank_r <= 3'h0;
      taddr_r <= 32'h0000_0000;
      tdata_r <= 16'h0000;
      pcnt_r  <= 16'h0000;
      pbank_r <= 3'h0;
      paddr_r <= 32'h0000_0000;
      ecnt_r  <= 16'h0000;
      ebank_r <= 3'h0;
      eaddr_r <= 32'h0000_0000;
      sector_locked_flag_r <= 1'b0;
      command_status_flag_r <= 1'b0;
      supe_r  <= 1'b0;
      invd_r  <= 1'b0;
    end else begin
      case (st_r)
        fcsm_pkg::ST_IDLE: begin
          if (cmd_ok && new_ok) begin
            kind_r <= is_erase ? fcsm_pkg::OPK_ERASE :
                      is_valid ? fcsm_pkg::OPK_VALID :
                                 fcsm_pkg::OPK_PROG;
            st_r   <= fcsm_pkg::ST_WAIT_DATA;
          end else if (do_resp) begin
            kind_r  <= fcsm_pkg::OPK_PROG;
            taddr_r <= paddr_r;
            tbank_r <= pbank_r;
            cnt_r   <= pcnt_r;
            psusp_r <= 1'b0;
            st_r    <= fcsm_pkg::ST_CHECK;
          end else if (do_rese) begin
            kind_r  <= fcsm_pkg::OPK_ERASE;
            taddr_r <= eaddr_r;
            tbank_r <= ebank_r;
            cnt_r   <= ecnt_r;
            esusp_r <= 1'b0;
            st_r    <= fcsm_pkg::ST_CHECK;
          end else if (cmd_ok && is_clr) begin
            sector_locked_flag_r <= 1'b0;
            command_status_flag_r <= 1'b0;
            supe_r  <= 1'b0;
            invd_r  <= 1'b0;
          end
        end
        fcsm_pkg::ST_WAIT_DATA: begin
          // other register traffic leaves the pending job alone
          if (wr_dat) begin
            taddr_r <= {12'h000, wd_r[31:16], 4'h0};
            tdata_r <= wd_r[15:0];
            tbank_r <= sel_bank;
            cnt_r   <= kind_r == fcsm_pkg::OPK_ERASE ?
                       16'(`FCSM_ERASE_CYC) : 16'(`FCSM_PROG_CYC);
            st_r    <= fcsm_pkg::ST_CHECK;
          end
        end
        fcsm_pkg::ST_CHECK: begin
          if (kind_r != fcsm_pkg::OPK_VALID && !sec_ok) begin
            sector_locked_flag_r <= 1'b1;
            command_status_flag_r <= 1'b1;
            st_r    <= fcsm_pkg::ST_IDLE;
          end else begin
            st_r <= fcsm_pkg::ST_RUN;
          end
        end
        fcsm_pkg::ST_RUN: begin
          if (sup_flt_r && run_pe)
            supe_r <= 1'b1;
          if (do_susp) begin
            scnt_r <= 9'(SUSP_CYC);
            st_r   <= fcsm_pkg::ST_SUSPENDING;
          end else if (cnt_r <= 16'h0001) begin
            st_r <= fcsm_pkg::ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 16'h0001;
          end
        end
        fcsm_pkg::ST_SUSPENDING: begin
          if (scnt_r <= 9'h001) begin
            st_r <= fcsm_pkg::ST_IDLE;
            if (kind_r == fcsm_pkg::OPK_ERASE) begin
              esusp_r <= 1'b1;
              ecnt_r  <= cnt_r;
              ebank_r <= tbank_r;
              eaddr_r <= taddr_r;
            end else begin
              psusp_r <= 1'b1;
              pcnt_r  <= cnt_r;
              pbank_r <= tbank_r;
              paddr_r <= taddr_r;
            end
          end else begin
            scnt_r <= scnt_r - 9'h001;
          end
        end
        default: st_r <= fcsm_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read validity check for a probed address (bank in bits 31:29)
  // ----------------------------------------------------------------
  wire [2:0] chk_bank = rdchk_r[31:29];
  wire [31:0] chk_addr = {12'h000, rdchk_r[15:0], 4'h0};
  wire bad_run  = run_pe && chk_bank == tbank_r;
  wire bad_ps   = psusp_r && chk_bank == pbank_r &&
                  chk_addr == paddr_r;
  wire bad_es   = esusp_r && chk_bank == ebank_r &&
                  chk_addr[20:16] == eaddr_r[20:16];
  wire chk_inv  = bad_run || bad_ps || bad_es;

  // ----------------------------------------------------------------
  // read channel and busy output
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    case (i_araddr)
      `FCSM_OFS_CTRL:   rd_mux = ctrl_r;
      `FCSM_OFS_SECTEN: rd_mux = secen_r;
      `FCSM_OFS_STAT:   rd_mux = {25'h0, esusp_r, psusp_r, invd_r,
                                  supe_r, busy, command_status_flag_r, sector_locked_flag_r};
      `FCSM_OFS_DATA:   rd_mux = {16'h0, tdata_r};
      `FCSM_OFS_RDCHK:  rd_mux = {31'h0, chk_inv};
      `FCSM_OFS_SUPPLY: rd_mux = {31'h0, sup_flt_r};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= 2'h0;
      o_busy    <= 1'b0;
    end else begin
      o_busy    <= busy;
      o_arready <= !o_rvalid && !(i_arvalid && o_arready);
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rdata  <= rd_mux;
        o_rresp  <= addr_ok(i_araddr) ? 2'h0 : 2'h2;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ---- sim/fcsm_chk_sva.sv ----
// checker: port-level properties of the flash command sequencer
// assumes bind onto fcsm_top, one clock, sync active-low reset
`timescale 1ns/1ps
`include "fcsm_cfg.svh"
module fcsm_chk #(
  parameter int SUSP_CYC = 100
) (
  input wire logic        i_clk_sys,
  input wire logic        i_nrst,
  input wire logic [11:0] i_awaddr,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic [11:0] i_araddr,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [1:0]  o_rresp,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic        o_busy
);
  // ------------------------------------------------------------
  // command tracking
  // ------------------------------------------------------------
  logic [11:0] aw_r;
  logic [15:0] op_r;
  logic        susp_r;
  logic        val_r;
  int          cnt_r;
  wire         cmd_ev = o_bvalid && i_bready && aw_r == `FCSM_OFS_CMD;

  // last write address and operand, as the response goes out
  always_ff @(posedge i_clk_sys) begin
    if (i_awvalid && o_awready)
      aw_r <= i_awaddr;
    if (i_wvalid && o_wready)
      op_r <= i_wdata[15:0];
  end

  // time a pending suspend; validate jobs cannot be suspended
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      susp_r <= 1'b0;
      val_r  <= 1'b0;
      cnt_r  <= 0;
    end else begin
      if (cmd_ev && !o_busy && op_r != `FCSM_OP_SUSP)
        val_r <= op_r == `FCSM_OP_VALID;
      susp_r <= o_busy && (susp_r ||
                (cmd_ev && op_r == `FCSM_OP_SUSP && !val_r));
      cnt_r  <= (susp_r && o_busy) ? cnt_r + 1 : 0;
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  chk_b_hold: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp)) else $error("write response dropped");
  chk_r_hold: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rresp)) else $error("read response dropped");
  chk_rd_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  chk_aw_once: assert property (i_awvalid && o_awready |=> !o_awready)
    else $error("address ready while holding a word");
  chk_bad_addr: assert property (i_arvalid && o_arready &&
    i_araddr > 12'h018 |=> o_rresp == 2'b10)
    else $error("unmapped read not refused");
  chk_reset_idle: assert property (disable iff (1'b0)
    !i_nrst |=> !o_busy && !o_bvalid && !o_rvalid)
    else $error("outputs active after reset");
  chk_clr_quiet: assert property (cmd_ev && op_r == `FCSM_OP_CLR &&
    !o_busy |=> !o_busy [*3]) else $error("clear status raised busy");
  chk_susp_idle: assert property (cmd_ev && op_r == `FCSM_OP_SUSP &&
    !o_busy |=> !o_busy [*3]) else $error("idle suspend raised busy");
  chk_susp_bound: assert property (cnt_r <= SUSP_CYC + 6)
    else $error("busy held too long after suspend");
endmodule

// ---- sim/fcsm_host.sv ----
// host model: AXI4-Lite master issuing register and command writes
// assumes tasks are called one at a time from a single process
`timescale 1ns/1ps
`include "fcsm_cfg.svh"
module fcsm_host (
  input  wire logic        i_clk_sys,
  output logic [11:0]      o_awaddr,
  output logic             o_awvalid,
  input  wire logic        i_awready,
  output logic [31:0]      o_wdata,
  output logic             o_wvalid,
  input  wire logic        i_wready,
  input  wire logic [1:0]  i_bresp,
  input  wire logic        i_bvalid,
  output logic             o_bready,
  output logic [11:0]      o_araddr,
  output logic             o_arvalid,
  input  wire logic        i_arready,
  input  wire logic [31:0] i_rdata,
  input  wire logic [1:0]  i_rresp,
  input  wire logic        i_rvalid,
  output logic             o_rready
);
  // idle bus at time zero
  initial begin
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
    o_awaddr = 12'h000;
    o_araddr = 12'h000;
    o_wdata = 32'h0000_0000;
  end

  // address and data offered together; released lines show junk
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge i_clk_sys);
    o_awaddr <= a;
    o_wdata <= d;
    {o_awvalid, o_wvalid, o_bready} <= 3'h7;
    while (!done) begin
      @(posedge i_clk_sys);
      if (o_awvalid && i_awready) begin
        o_awvalid <= 1'b0;
        o_awaddr <= ~a;
      end
      if (o_wvalid && i_wready) begin
        o_wvalid <= 1'b0;
        o_wdata <= ~d;
      end
      if (o_bready && i_bvalid) begin
        r = i_bresp;
        o_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // single read, rready held until the answer
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge i_clk_sys);
    o_araddr <= a;
    {o_arvalid, o_rready} <= 2'h3;
    while (!done) begin
      @(posedge i_clk_sys);
      if (o_arvalid && i_arready) begin
        o_arvalid <= 1'b0;
        o_araddr <= ~a;
      end
      if (o_rready && i_rvalid) begin
        d = i_rdata;
        r = i_rresp;
        o_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // two-write command: operand, then one target half-word
  task automatic job(input logic [15:0] op, input logic [31:0] tgt);
    logic [1:0] r;
    wr(`FCSM_OFS_CMD, {16'h0000, op}, r);
    wr(`FCSM_OFS_DATA, tgt, r);
  endtask
endmodule

// ---- sim/tb_flash_command_state_machine.sv ----
// testbench: command sequences over AXI4-Lite against the sequencer
// assumes fcsm_host drives the bus and fcsm_chk is bound below
`timescale 1ns/1ps
`include "fcsm_cfg.svh"
module tb_flash_command_state_machine;
  localparam int SUSP = 20;
  logic        i_clk_sys = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_supply_fault = 1'b0;
  logic [11:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, rv;
  logic [1:0]  o_bresp, o_rresp, rs;
  logic        i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid;
  logic        i_bready, i_arvalid, o_arready, o_rvalid, i_rready;
  logic        o_busy;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          n;

  fcsm_top #(.SUSP_CYC(SUSP)) fcsm_top_i (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_supply_fault(i_supply_fault),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(4'hF), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_busy(o_busy));
  fcsm_host fcsm_host_i (
    .i_clk_sys(i_clk_sys), .o_awaddr(i_awaddr), .o_awvalid(i_awvalid),
    .i_awready(o_awready), .o_wdata(i_wdata), .o_wvalid(i_wvalid),
    .i_wready(o_wready), .i_bresp(o_bresp), .i_bvalid(o_bvalid),
    .o_bready(i_bready), .o_araddr(i_araddr), .o_arvalid(i_arvalid),
    .i_arready(o_arready), .i_rdata(o_rdata), .i_rresp(o_rresp),
    .i_rvalid(o_rvalid), .o_rready(i_rready));

  // 200 MHz clock and a cycle ceiling against hangs
  initial begin
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    fcsm_host_i.wr(a, d, rs);
    cmp({30'h0, rs}, 32'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    fcsm_host_i.rd(a, rv, rs);
    cmp(rv & m, e);
  endtask
  // read-check port: bit 0 tells whether that read would be invalid
  task automatic chk_inv(input logic [31:0] ad, input logic e);
    wr(`FCSM_OFS_RDCHK, ad);
    rd(`FCSM_OFS_RDCHK, {31'h0, e}, 32'h1);
  endtask
  task automatic wait_busy(input logic lv, input int lim);
    n = 0;
    while (o_busy !== lv && n < lim) begin
      @(posedge i_clk_sys);
      n++;
    end
    cmp({31'h0, o_busy}, {31'h0, lv});
  endtask
  task automatic quiet(input int k);
    logic seen;
    seen = 1'b0;
    repeat (k) begin
      @(posedge i_clk_sys);
      seen = seen | o_busy;
    end
    cmp({31'h0, seen}, 32'h0);
  endtask
  task automatic cmd(input logic [15:0] op);
    wr(`FCSM_OFS_CMD, {16'h0000, op});
  endtask
  task automatic print_verdict();
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    rd(`FCSM_OFS_STAT, 32'h0, 32'hFFFF_FFFF);
    fcsm_host_i.rd(12'h0FC, rv, rs);
    cmp({30'h0, rs}, 32'h2);
    wr(`FCSM_OFS_CTRL, 32'h0000_0015);
    rd(`FCSM_OFS_CTRL, 32'h0, 32'h1);
    wr(`FCSM_OFS_CTRL, 32'h0000_0111);
    fcsm_host_i.job(`FCSM_OP_PROG, 32'h0040_A5A5);
    quiet(20);
    wr(`FCSM_OFS_CTRL, 32'h0000_0110);
    fcsm_host_i.job(`FCSM_OP_PROG, 32'h0040_A5A5);
    repeat (8) @(posedge i_clk_sys);
    rd(`FCSM_OFS_STAT, 32'h1, 32'h5);
    cmd(`FCSM_OP_CLR);
    rd(`FCSM_OFS_STAT, 32'h0, 32'h1F);
    wr(`FCSM_OFS_SECTEN, 32'hFFFF_FFFF);
    cmd(`FCSM_OP_PROG);
    rd(`FCSM_OFS_SECTEN, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    rd(`FCSM_OFS_STAT, 32'h0, 32'h4);
    wr(`FCSM_OFS_DATA, 32'h0040_A5A5);
    wait_busy(1'b1, 4);
    rd(`FCSM_OFS_DATA, 32'h0000_A5A5, 32'hFFFF_FFFF);
    chk_inv(32'h2000_0040, 1'b1);
    chk_inv(32'h4000_0040, 1'b0);
    cmd(`FCSM_OP_ERASE);
    wait_busy(1'b0, 80);
    cmp({31'h0, n > 20}, 32'h1);
    quiet(300);
    fcsm_host_i.job(`FCSM_OP_PROG, 32'h0040_A5A5);
    wait_busy(1'b1, 4);
    cmd(`FCSM_OP_SUSP);
    wait_busy(1'b0, SUSP + 8);
    rd(`FCSM_OFS_STAT, 32'h20, 32'h64);
    chk_inv(32'h2000_0040, 1'b1);
    chk_inv(32'h2000_0042, 1'b0);
    fcsm_host_i.job(`FCSM_OP_PROG, 32'h0044_1111);
    cmd(`FCSM_OP_RESE);
    quiet(20);
    wr(`FCSM_OFS_CTRL, 32'h0000_0210);
    fcsm_host_i.job(`FCSM_OP_ERASE, 32'h0000_0000);
    wait_busy(1'b1, 4);
    cmd(`FCSM_OP_SUSP);
    wait_busy(1'b0, SUSP + 8);
    chk_inv(32'h4000_0000, 1'b1);
    cmd(`FCSM_OP_RESE);
    wait_busy(1'b1, 4);
    wait_busy(1'b0, 400);
    rd(`FCSM_OFS_STAT, 32'h20, 32'h64);
    cmd(`FCSM_OP_RESP);
    wait_busy(1'b1, 4);
    wait_busy(1'b0, 80);
    rd(`FCSM_OFS_STAT, 32'h0, 32'h64);
    fcsm_host_i.job(`FCSM_OP_OTP, 32'h0050_1234);
    wait_busy(1'b1, 4);
    wait_busy(1'b0, 80);
    fcsm_host_i.job(`FCSM_OP_VALID, 32'h0050_0000);
    wait_busy(1'b1, 4);
    wait_busy(1'b0, 300);
    fcsm_host_i.job(`FCSM_OP_PROG, 32'h0060_0F0F);
    wait_busy(1'b1, 4);
    i_supply_fault <= 1'b1;
    repeat (10) @(posedge i_clk_sys);
    i_supply_fault <= 1'b0;
    wait_busy(1'b0, 80);
    rd(`FCSM_OFS_STAT, 32'h8, 32'h8);
    cmd(`FCSM_OP_CLR);
    rd(`FCSM_OFS_STAT, 32'h0, 32'h8);
    cmd(`FCSM_OP_SUSP);
    quiet(10);
    fcsm_host_i.job(`FCSM_OP_ERASE, 32'h0000_0000);
    wait_busy(1'b1, 4);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    rd(`FCSM_OFS_STAT, 32'h0, 32'hFFFF_FFFF);
    print_verdict();
  end
endmodule

bind fcsm_top fcsm_chk #(.SUSP_CYC(SUSP_CYC)) fcsm_chk_i (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_awaddr(i_awaddr),
  .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
  .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
  .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr),
  .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rresp(o_rresp),
  .o_rvalid(o_rvalid), .i_rready(i_rready), .o_busy(o_busy));
